//--- hw/slu_defines.svh
// constants for the stack linkage unit
`ifndef SLU_DEFINES_SVH
`define SLU_DEFINES_SVH
// ************************************
// register indices
// ************************************
`define SLU_SYS_SP_IDX 3'h6
`define SLU_PC_IDX 3'h7
// ************************************
// pointer steps and vector layout
// ************************************
`define SLU_WORD_STEP 16'h0002
`define SLU_BYTE_STEP 16'h0001
`define SLU_VEC_PSW_OFS 16'h0002
// ************************************
// reset values
// ************************************
`define SLU_GPR_RST 16'h0000
`define SLU_PSW_RST 16'h0000
`endif

//--- hw/slu_pkg.sv
// types for the stack linkage unit
package slu_pkg;
    typedef enum logic [2:0] {
        OP_PUSH = 3'b000,
        OP_POP = 3'b001,
        OP_CALL = 3'b010,
        OP_RET = 3'b011,
        OP_INT = 3'b100,
        OP_RTI = 3'b101
    } slu_op_t;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_PUSH = 4'b0001,
        ST_POP = 4'b0010,
        ST_CALL = 4'b0011,
        ST_RET = 4'b0100,
        ST_INT_PSW = 4'b0101,
        ST_INT_PC = 4'b0110,
        ST_INT_VPC = 4'b0111,
        ST_INT_VPSW = 4'b1000,
        ST_RTI_PC = 4'b1001,
        ST_RTI_PSW = 4'b1010
    } slu_state_t;
endpackage

//--- hw/slu_step.sv
// pointer step for autodecrement and autoincrement
`timescale 1ns/100ps
`default_nettype none
`include "slu_defines.svh"
module slu_step (
    // pointer in
    input wire logic [15:0] i_ptr,
    input wire logic [2:0] i_reg,
    input wire logic i_byte,
    // stepped values
    output logic [15:0] o_dec,
    output logic [15:0] o_inc
);
    logic [15:0] step;
    // the system pointer stays word aligned even for byte items
    assign step = (i_byte && i_reg != `SLU_SYS_SP_IDX) ? `SLU_BYTE_STEP : `SLU_WORD_STEP;
    assign o_dec = i_ptr - step;
    assign o_inc = i_ptr + step;
endmodule
`default_nettype wire

//--- hw/slu_top.sv
// stack linkage unit: stack pointers, push/pop, call, return, interrupt entry and exit
// Contract
// - stacks grow downward from the top of their region.
// - any register but the program counter may be a stack pointer.
// - call, return and interrupt linkage always use register six.
// - the system stack pointer only holds even word addresses.
// - other stacks may hold words or bytes, bytes stepping by one.
// - push decrements the pointer first, then writes at the new address.
// - pop reads at the pointer, then increments it past the item.
// - pointer always holds the address of the latest stored item.
// - call pushes link register, copies return address into it, jumps.
// - call with the program counter as link pushes the return address.
// - return moves link register to program counter, pops into link register.
// - interrupt entry pushes status word and program counter on system stack.
// - then program counter loads from vector word, status from the next.
// - interrupt return pops program counter, then status word.
// - nesting has no hardware depth limit.
`timescale 1ns/100ps
`default_nettype none
`include "slu_defines.svh"
module slu_top (
    // clock, reset, enable
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    input wire logic I_CE,
    // command port
    input wire logic I_CMD_VALID,
    input wire slu_pkg::slu_op_t I_CMD_OP,
    input wire logic [2:0] I_CMD_REG,
    input wire logic I_CMD_BYTE,
    input wire logic [15:0] I_CMD_DATA,
    output logic O_CMD_READY,
    output logic O_DONE,
    output logic O_ERR,
    output logic [15:0] O_POP_DATA,
    // register load port
    input wire logic I_REG_WE,
    input wire logic [2:0] I_REG_SEL,
    input wire logic [15:0] I_REG_WDATA,
    // register view
    output logic [15:0] O_PROGRAM_COUNTER_REGISTER,
    output logic [15:0] O_SYSTEM_STACK_POINTER,
    output logic [15:0] O_PROCESSOR_STATUS_WORD,
    // memory port
    output logic O_MEM_REQ,
    output logic O_MEM_WE,
    output logic O_MEM_BYTE,
    output logic [15:0] O_MEM_ADDR,
    output logic [15:0] O_MEM_WDATA,
    input wire logic I_MEM_ACK,
    input wire logic [15:0] I_MEM_RDATA
);
    import slu_pkg::*;

    // ************************************
    // state
    // ************************************
    typedef struct packed {
        slu_state_t state;
        logic [7:0][15:0] gpr;
        logic [15:0] processor_status_word;
        logic [2:0] lnk;
        logic byte_op;
        logic [15:0] vec;
        logic mreq;
        logic mwe;
        logic mbyte;
        logic [15:0] maddr;
        logic [15:0] mwdata;
        logic [15:0] pop_data;
        logic done;
        logic err;
    } slu_regs_t;

    slu_regs_t st;
    slu_regs_t next_st;
    logic cmd_take;
    logic ack;
    logic [2:0] ptr_sel;
    logic [15:0] ptr_dec;
    logic [15:0] ptr_inc;
    logic [15:0] sp;
    logic [15:0] sp_dec;
    logic [15:0] sp_inc;

    assign cmd_take = I_CE && I_CMD_VALID && st.state == ST_IDLE;
    assign ack = I_CE && I_MEM_ACK;
    assign ptr_sel = (st.state == ST_IDLE) ? I_CMD_REG : st.lnk;
    assign sp = st.gpr[`SLU_SYS_SP_IDX];
    // linkage traffic never uses any pointer but the system one
    assign sp_dec = sp - `SLU_WORD_STEP;
    assign sp_inc = sp + `SLU_WORD_STEP;

    slu_step u_step (
        .i_ptr(st.gpr[ptr_sel]),
        .i_reg(ptr_sel),
        .i_byte(st.state == ST_IDLE ? I_CMD_BYTE : st.byte_op),
        .o_dec(ptr_dec),
        .o_inc(ptr_inc)
    );

    // ************************************
    // next state
    // ************************************
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        next_st.err = 1'b0;
        case (st.state)
            ST_IDLE: begin
                if (cmd_take) begin
                    next_st.lnk = I_CMD_REG;
                    next_st.byte_op = I_CMD_BYTE;
                    next_st.vec = I_CMD_DATA;
                    next_st.mbyte = 1'b0;
                    case (I_CMD_OP)
                        OP_PUSH: begin
                            if (I_CMD_REG == `SLU_PC_IDX) begin
                                next_st.err = 1'b1;
                            end else begin
                                next_st.gpr[I_CMD_REG] = ptr_dec;
                                next_st.maddr = ptr_dec;
                                next_st.mreq = 1'b1;
                                next_st.mwe = 1'b1;
                                next_st.mbyte = I_CMD_BYTE;
                                next_st.mwdata = ptr_dec[0] ? {I_CMD_DATA[7:0], 8'h00} :
                                    (I_CMD_BYTE ? {8'h00, I_CMD_DATA[7:0]} : I_CMD_DATA);
                                next_st.state = ST_PUSH;
                            end
                        end
                        OP_POP: begin
                            if (I_CMD_REG == `SLU_PC_IDX) begin
                                next_st.err = 1'b1;
                            end else begin
                                next_st.maddr = st.gpr[I_CMD_REG];
                                next_st.mreq = 1'b1;
                                next_st.mwe = 1'b0;
                                next_st.mbyte = I_CMD_BYTE;
                                next_st.state = ST_POP;
                            end
                        end
                        OP_CALL: begin
                            next_st.gpr[`SLU_SYS_SP_IDX] = sp_dec;
                            next_st.maddr = sp_dec;
                            next_st.mwdata = st.gpr[I_CMD_REG];
                            next_st.mreq = 1'b1;
                            next_st.mwe = 1'b1;
                            next_st.state = ST_CALL;
                        end
                        OP_RET: begin
                            next_st.gpr[`SLU_PC_IDX] = st.gpr[I_CMD_REG];
                            next_st.maddr = sp;
                            next_st.mreq = 1'b1;
                            next_st.mwe = 1'b0;
                            next_st.state = ST_RET;
                        end
                        OP_INT: begin
                            next_st.gpr[`SLU_SYS_SP_IDX] = sp_dec;
                            next_st.maddr = sp_dec;
                            next_st.mwdata = st.processor_status_word;
                            next_st.mreq = 1'b1;
                            next_st.mwe = 1'b1;
                            next_st.state = ST_INT_PSW;
                        end
                        OP_RTI: begin
                            next_st.maddr = sp;
                            next_st.mreq = 1'b1;
                            next_st.mwe = 1'b0;
                            next_st.state = ST_RTI_PC;
                        end
                        default: begin
                            next_st.err = 1'b1;
                        end
                    endcase
                end else if (I_CE && I_REG_WE) begin
                    // bit zero of the system pointer cannot be set
                    next_st.gpr[I_REG_SEL] = (I_REG_SEL == `SLU_SYS_SP_IDX) ?
                        {I_REG_WDATA[15:1], 1'b0} : I_REG_WDATA;
                end
            end
            ST_PUSH: begin
                if (ack) begin
                    next_st.mreq = 1'b0;
                    next_st.done = 1'b1;
                    next_st.state = ST_IDLE;
                end
            end
            ST_POP: begin
                if (ack) begin
                    next_st.pop_data = !st.byte_op ? I_MEM_RDATA :
                        (st.maddr[0] ? {8'h00, I_MEM_RDATA[15:8]} : {8'h00, I_MEM_RDATA[7:0]});
                    next_st.gpr[st.lnk] = ptr_inc;
                    next_st.mreq = 1'b0;
                    next_st.done = 1'b1;
                    next_st.state = ST_IDLE;
                end
            end
            ST_CALL: begin
                if (ack) begin
                    if (st.lnk != `SLU_PC_IDX) begin
                        next_st.gpr[st.lnk] = st.gpr[`SLU_PC_IDX];
                    end
                    // an odd return address must not make the system pointer odd
                    if (st.lnk == `SLU_SYS_SP_IDX) begin
                        next_st.gpr[st.lnk] = {st.gpr[`SLU_PC_IDX][15:1], 1'b0};
                    end
                    next_st.gpr[`SLU_PC_IDX] = st.vec;
                    next_st.mreq = 1'b0;
                    next_st.done = 1'b1;
                    next_st.state = ST_IDLE;
                end
            end
            ST_RET: begin
                if (ack) begin
                    next_st.gpr[st.lnk] = I_MEM_RDATA;
                    next_st.gpr[`SLU_SYS_SP_IDX] = sp_inc;
                    next_st.mreq = 1'b0;
                    next_st.done = 1'b1;
                    next_st.state = ST_IDLE;
                end
            end
            ST_INT_PSW: begin
                if (ack) begin
                    next_st.gpr[`SLU_SYS_SP_IDX] = sp_dec;
                    next_st.maddr = sp_dec;
                    next_st.mwdata = st.gpr[`SLU_PC_IDX];
                    next_st.state = ST_INT_PC;
                end
            end
            ST_INT_PC: begin
                if (ack) begin
                    next_st.maddr = st.vec;
                    next_st.mwe = 1'b0;
                    next_st.state = ST_INT_VPC;
                end
            end
            ST_INT_VPC: begin
                if (ack) begin
                    next_st.gpr[`SLU_PC_IDX] = I_MEM_RDATA;
                    next_st.maddr = st.vec + `SLU_VEC_PSW_OFS;
                    next_st.state = ST_INT_VPSW;
                end
            end
            ST_INT_VPSW: begin
                if (ack) begin
                    next_st.processor_status_word = I_MEM_RDATA;
                    next_st.mreq = 1'b0;
                    next_st.done = 1'b1;
                    next_st.state = ST_IDLE;
                end
            end
            ST_RTI_PC: begin
                if (ack) begin
                    next_st.gpr[`SLU_PC_IDX] = I_MEM_RDATA;
                    next_st.gpr[`SLU_SYS_SP_IDX] = sp_inc;
                    next_st.maddr = sp_inc;
                    next_st.state = ST_RTI_PSW;
                end
            end
            ST_RTI_PSW: begin
                if (ack) begin
                    next_st.processor_status_word = I_MEM_RDATA;
                    next_st.gpr[`SLU_SYS_SP_IDX] = sp_inc;
                    next_st.mreq = 1'b0;
                    next_st.done = 1'b1;
                    next_st.state = ST_IDLE;
                end
            end
            default: begin
                next_st.state = ST_IDLE;
            end
        endcase
    end

    // no depth counter: the pointer simply wraps, nesting is unbounded
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            st <= '0;
            st.state <= ST_IDLE;
            st.gpr <= {8{`SLU_GPR_RST}};
            st.processor_status_word <= `SLU_PSW_RST;
        end else if (I_CE) begin
            st <= next_st;
        end
    end

    // ************************************
    // outputs
    // ************************************
    assign O_CMD_READY = st.state == ST_IDLE;
    assign O_DONE = st.done;
    assign O_ERR = st.err;
    assign O_POP_DATA = st.pop_data;
    assign O_PROGRAM_COUNTER_REGISTER = st.gpr[`SLU_PC_IDX];
    assign O_SYSTEM_STACK_POINTER = sp;
    assign O_PROCESSOR_STATUS_WORD = st.processor_status_word;
    assign O_MEM_REQ = st.mreq;
    assign O_MEM_WE = st.mwe;
    assign O_MEM_BYTE = st.mbyte;
    assign O_MEM_ADDR = st.maddr;
    assign O_MEM_WDATA = st.mwdata;

    // ************************************
    // checks
    // ************************************
    sequence int_pushes_s;
        st.state == ST_INT_PSW && ack ##1 st.state == ST_INT_PC;
    endsequence
    sequence int_vector_s;
        st.state == ST_INT_PC && ack ##1 st.state == ST_INT_VPC;
    endsequence

    sp_even_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST) sp[0] == 1'b0)
        else $error("system stack pointer odd");
    pc_no_ptr_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        cmd_take && I_CMD_REG == `SLU_PC_IDX && (I_CMD_OP == OP_PUSH || I_CMD_OP == OP_POP)
        |=> O_ERR && st.state == ST_IDLE) else $error("program counter used as pointer");
    push_addr_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        st.state == ST_PUSH |-> O_MEM_WE && O_MEM_ADDR == st.gpr[st.lnk]) else $error("push address wrong");
    pop_step_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        st.state == ST_POP && ack |=> st.gpr[st.lnk] > $past(O_MEM_ADDR) || $past(O_MEM_ADDR) > 16'hfffd)
        else $error("pop did not advance pointer");
    call_sp_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        cmd_take && I_CMD_OP == OP_CALL |=> sp == $past(sp) - `SLU_WORD_STEP && O_MEM_ADDR == sp)
        else $error("call push wrong");
    call_jump_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        st.state == ST_CALL && ack |=> O_PROGRAM_COUNTER_REGISTER == $past(st.vec) && O_DONE)
        else $error("call did not jump");
    int_order_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        int_pushes_s |-> O_MEM_WE && O_MEM_WDATA == O_PROGRAM_COUNTER_REGISTER && O_MEM_ADDR == sp)
        else $error("interrupt push order wrong");
    int_vec_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        int_vector_s |-> !O_MEM_WE && O_MEM_ADDR == st.vec) else $error("vector fetch wrong");
    rti_pop_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        st.state == ST_RTI_PC && ack |=> O_PROGRAM_COUNTER_REGISTER == $past(I_MEM_RDATA)
        && sp == $past(sp) + `SLU_WORD_STEP) else $error("rti pop wrong");
endmodule
`default_nettype wire

//--- testbench/slu_mem_model.sv
// main memory model holding the stack area
`timescale 1ns/100ps
`default_nettype none
module slu_mem_model (
    // clock
    input wire logic i_clk,
    input wire logic i_ce,
    // memory port
    input wire logic i_req,
    input wire logic i_we,
    input wire logic i_byte,
    input wire logic [15:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic [1:0] i_wait,
    output logic o_ack,
    output logic [15:0] o_rdata
);
    logic [15:0] mem [0:255];
    logic [1:0] cnt;
    initial begin
        o_ack = 1'b0;
        o_rdata = 16'h0000;
        cnt = 2'h0;
        for (int k = 0; k < 256; k++) begin
            mem[k] = 16'h0000;
        end
    end
    always @(posedge i_clk) begin
        if (o_ack && i_req && i_ce && i_we) begin
            if (i_byte && i_addr[0]) begin
                mem[i_addr[8:1]][15:8] <= i_wdata[15:8];
            end else if (i_byte) begin
                mem[i_addr[8:1]][7:0] <= i_wdata[7:0];
            end else begin
                mem[i_addr[8:1]] <= i_wdata;
            end
        end
        // no ack: data line toggles so stale values never pass
        // an ack given while the enable is low stays up until it is taken
        if ((o_ack && i_ce) || !i_req) begin
            o_ack <= 1'b0;
            o_rdata <= ~o_rdata;
            cnt <= 2'h0;
        end else if (cnt == i_wait) begin
            o_ack <= 1'b1;
            o_rdata <= mem[i_addr[8:1]];
        end else begin
            cnt <= cnt + 2'h1;
            o_rdata <= ~o_rdata;
        end
    end
endmodule
`default_nettype wire

//--- testbench/stack_linkage_unit_test.sv
// self-checking bench for the stack linkage unit
`timescale 1ns/100ps
`default_nettype none
module stack_linkage_unit_test;
    import slu_pkg::*;
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, valid = 1'b0, cbyte = 1'b0, rwe = 1'b0;
    slu_op_t op = OP_PUSH;
    logic [2:0] creg = 3'h0, rsel = 3'h0;
    logic [15:0] cdata = 16'h0000, rwdata = 16'h0000;
    logic [1:0] mwait = 2'h0;
    logic ready, done, err, mreq, mwe, mbyte, mack, got_err;
    logic [15:0] pop_data, pc, sp, processor_status_word, maddr, mwdata, mrdata, last_addr;
    int error_cnt = 0;
    int checks_done = 0;
    // ************************************
    // instances
    // ************************************
    slu_top u_dut (.I_SYS_CLK(clk), .I_RST(rst), .I_CE(ce), .I_CMD_VALID(valid), .I_CMD_OP(op),
        .I_CMD_REG(creg), .I_CMD_BYTE(cbyte), .I_CMD_DATA(cdata), .O_CMD_READY(ready), .O_DONE(done),
        .O_ERR(err), .O_POP_DATA(pop_data), .I_REG_WE(rwe), .I_REG_SEL(rsel), .I_REG_WDATA(rwdata),
        .O_PROGRAM_COUNTER_REGISTER(pc), .O_SYSTEM_STACK_POINTER(sp), .O_PROCESSOR_STATUS_WORD(processor_status_word),
        .O_MEM_REQ(mreq), .O_MEM_WE(mwe), .O_MEM_BYTE(mbyte), .O_MEM_ADDR(maddr), .O_MEM_WDATA(mwdata),
        .I_MEM_ACK(mack), .I_MEM_RDATA(mrdata));
    slu_mem_model u_mem (.i_clk(clk), .i_ce(ce), .i_req(mreq), .i_we(mwe), .i_byte(mbyte), .i_addr(maddr),
        .i_wdata(mwdata), .i_wait(mwait), .o_ack(mack), .o_rdata(mrdata));
    initial begin
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        if (mreq && mack && ce) begin
            last_addr <= maddr;
        end
    end
    // ************************************
    // helpers
    // ************************************
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
            error_cnt++;
        end
    endtask
    function automatic logic [15:0] mw(input logic [15:0] a);
        return u_mem.mem[a[8:1]];
    endfunction
    task automatic load(input logic [2:0] r, input logic [15:0] d);
        @(negedge clk);
        rwe = 1'b1;
        rsel = r;
        rwdata = d;
        @(negedge clk);
        rwe = 1'b0;
    endtask
    // only ever issued while idle, so it is taken at the first edge
    task automatic cmd(input slu_op_t o, input logic [2:0] r, input logic b, input logic [15:0] d);
        int n;
        n = 0;
        @(negedge clk);
        valid = 1'b1;
        op = o;
        creg = r;
        cbyte = b;
        cdata = d;
        @(negedge clk);
        valid = 1'b0;
        while (done !== 1'b1 && err !== 1'b1 && n < 60) begin
            @(negedge clk);
            n++;
        end
        got_err = err;
        check("completion", {15'h0, n < 60}, 16'h0001);
    endtask
    task automatic summarize;
        if (error_cnt == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ************************************
    // scenarios
    // ************************************
    task automatic t_word_stack;
        load(3'h3, 16'h0040);
        cmd(OP_PUSH, 3'h3, 1'b0, 16'h1234);
        check("push1 addr", last_addr, 16'h003e);
        cmd(OP_PUSH, 3'h3, 1'b0, 16'h5678);
        check("push2 addr", last_addr, 16'h003c);
        check("push2 mem", mw(16'h003c), 16'h5678);
        cmd(OP_POP, 3'h3, 1'b0, 16'h0000);
        check("pop1 addr", last_addr, 16'h003c);
        check("pop1 data", pop_data, 16'h5678);
        cmd(OP_POP, 3'h3, 1'b0, 16'h0000);
        check("pop2 data", pop_data, 16'h1234);
        cmd(OP_PUSH, 3'h3, 1'b0, 16'h0bad);
        check("push3 addr", last_addr, 16'h003e);
    endtask
    task automatic t_byte_stack;
        load(3'h2, 16'h0051);
        cmd(OP_PUSH, 3'h2, 1'b1, 16'h00ab);
        check("byte1 addr", last_addr, 16'h0050);
        cmd(OP_PUSH, 3'h2, 1'b1, 16'hcdcd);
        check("byte2 addr", last_addr, 16'h004f);
        check("byte2 lane", mw(16'h004e) & 16'hff00, 16'hcd00);
        check("byte1 lane", mw(16'h0050) & 16'h00ff, 16'h00ab);
        cmd(OP_POP, 3'h2, 1'b1, 16'h0000);
        check("byte pop", pop_data, 16'h00cd);
    endtask
    task automatic t_sys_sp;
        load(3'h6, 16'h0101);
        check("sp even", sp, 16'h0100);
        cmd(OP_PUSH, 3'h6, 1'b1, 16'h0011);
        check("sp byte step", sp, 16'h00fe);
        cmd(OP_POP, 3'h6, 1'b1, 16'h0000);
        check("sp byte pop", sp, 16'h0100);
    endtask
    task automatic t_refused;
        load(3'h7, 16'h0800);
        cmd(OP_PUSH, 3'h7, 1'b0, 16'h0001);
        check("pc push err", {15'h0, got_err}, 16'h0001);
        check("pc unchanged", pc, 16'h0800);
        cmd(OP_POP, 3'h7, 1'b0, 16'h0000);
        check("pc pop err", {15'h0, got_err}, 16'h0001);
        cmd(slu_op_t'(3'h6), 3'h3, 1'b0, 16'h0000);
        check("bad op err", {15'h0, got_err}, 16'h0001);
        check("sp kept", sp, 16'h0100);
        @(negedge clk);
        ce = 1'b0;
        op = OP_PUSH;
        creg = 3'h3;
        cbyte = 1'b0;
        valid = 1'b1;
        repeat (3) @(negedge clk);
        check("frozen req", {15'h0, mreq}, 16'h0000);
        check("frozen ready", {15'h0, ready}, 16'h0001);
        valid = 1'b0;
        ce = 1'b1;
    endtask
    task automatic t_call_ret;
        load(3'h7, 16'h1000);
        load(3'h5, 16'h5555);
        cmd(OP_CALL, 3'h5, 1'b0, 16'h2000);
        check("call mem", mw(16'h00fe), 16'h5555);
        check("call sp", sp, 16'h00fe);
        check("call pc", pc, 16'h2000);
        cmd(OP_CALL, 3'h7, 1'b0, 16'h3000);
        check("pc link mem", mw(16'h00fc), 16'h2000);
        check("pc link pc", pc, 16'h3000);
        cmd(OP_RET, 3'h7, 1'b0, 16'h0000);
        check("ret pc", pc, 16'h2000);
        check("ret sp", sp, 16'h00fe);
        cmd(OP_RET, 3'h5, 1'b0, 16'h0000);
        check("ret5 pc", pc, 16'h1000);
        check("ret5 sp", sp, 16'h0100);
        cmd(OP_PUSH, 3'h5, 1'b0, 16'h0000);
        check("link restored", last_addr, 16'h5553);
    endtask
    task automatic t_int_rti;
        mwait = 2'h2;
        u_mem.mem[8'h40] = 16'h4000;
        u_mem.mem[8'h41] = 16'h00e0;
        u_mem.mem[8'h42] = 16'h5000;
        u_mem.mem[8'h43] = 16'h0040;
        load(3'h7, 16'h1234);
        cmd(OP_INT, 3'h0, 1'b0, 16'h0080);
        check("int psw saved", mw(16'h00fe), 16'h0000);
        check("int pc saved", mw(16'h00fc), 16'h1234);
        check("int pc", pc, 16'h4000);
        check("int psw", processor_status_word, 16'h00e0);
        cmd(OP_INT, 3'h0, 1'b0, 16'h0084);
        check("nest psw", mw(16'h00fa), 16'h00e0);
        check("nest pc", mw(16'h00f8), 16'h4000);
        check("nest sp", sp, 16'h00f8);
        cmd(OP_RTI, 3'h0, 1'b0, 16'h0000);
        check("rti1 pc", pc, 16'h4000);
        check("rti1 psw", processor_status_word, 16'h00e0);
        cmd(OP_RTI, 3'h0, 1'b0, 16'h0000);
        check("rti2 pc", pc, 16'h1234);
        check("rti2 psw", processor_status_word, 16'h0000);
        check("rti2 sp", sp, 16'h0100);
        mwait = 2'h0;
    endtask
    // ************************************
    // main sequence and watchdog
    // ************************************
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        check("reset ready", {15'h0, ready}, 16'h0001);
        check("reset sp", sp, 16'h0000);
        t_word_stack();
        t_byte_stack();
        t_sys_sp();
        t_refused();
        t_call_ret();
        t_int_rti();
        summarize();
    end
    initial begin
        #100000;
        error_cnt++;
        summarize();
    end
endmodule
`default_nettype wire
